// ---- pkg/dmr1c_defines.vh ----
// Purpose: Constants for the first DRAM mode register controller
// Assumes: Device clock equals pclk; APB register map of our own
// Notes:   All offsets, field positions and counts live here
// Operation
// RL1: Device clears DLL reset bit itself
// RL2: Issue DLL reset after enabling DLL
// RL3: Wait lock cycles before reads or termination
// RL4: Keep clock enable high during lock wait
// RL5: Mode set: row, column, write strobes low
// RL6: Payload bits 20:18 select target register
// RL7: Reserved bits 21 and 17 written 0
// RL8: Bit 12 disables outputs and termination
// RL9: Bit 11 enables extra termination strobe
// RL10: Bits 10:8 select nominal termination
// RL11: Bit 7 enters write leveling mode
// RL12: Receive equaliser bits 13,6,5 written 000
// RL13: Bits 4:3 select additive latency
// RL14: No latency minus one with gear-down
// RL15: Bits 2:1 select driver strength
// RL16: Bit 0 enables the DLL
// RL17: DLL follows self refresh automatically
// RL18: Writes need DLL only with termination
// RL19: DLL off: nominal termination off, pin low
// RL20: DLL off: write-time termination disabled
// RL21: Write-time termination applies without nominal
// RL22: Parked termination applies when pin low
// RL23: Commands held by additive latency internally
// RL24: Read latency is additive plus CAS latency
`ifndef DMR1C_DEFINES_VH
`define DMR1C_DEFINES_VH
// APB register offsets
`define DMR1C_OFS_MR1_CFG     12'h000
`define DMR1C_OFS_MR0_IMAGE   12'h004
`define DMR1C_OFS_COMMAND     12'h008
`define DMR1C_OFS_STATUS      12'h00C
// Mode register payload fields
`define DMR1C_BIT_RSVD_HI     21
`define DMR1C_BIT_RSVD_LO     17
`define DMR1C_SEL_HI          20
`define DMR1C_SEL_LO          18
`define DMR1C_SEL_MR0         3'h0
`define DMR1C_SEL_MR1         3'h1
`define DMR1C_BIT_EQ_HI       13
`define DMR1C_BIT_OUT_OFF     12
`define DMR1C_BIT_EXTRA_TS    11
`define DMR1C_NT_HI           10
`define DMR1C_NT_LO           8
`define DMR1C_BIT_WLEVEL      7
`define DMR1C_BIT_EQ_MID      6
`define DMR1C_BIT_EQ_LO       5
`define DMR1C_AL_HI           4
`define DMR1C_AL_LO           3
`define DMR1C_DS_HI           2
`define DMR1C_DS_LO           1
`define DMR1C_BIT_DLL_EN      0
`define DMR1C_BIT_DLL_RESET   8
`define DMR1C_AL_MINUS_ONE    2'h1
`define DMR1C_NT_OFF          3'h0
// Writable bit mask of the MR1 image and its reset value
`define DMR1C_MR1_MASK        22'h00_1F9F
`define DMR1C_MR1_RESET       22'h00_0001
// Command register bits
`define DMR1C_CMD_APPLY       0
`define DMR1C_CMD_DLL_RESET   1
// Status register bits
`define DMR1C_ST_BUSY         0
`define DMR1C_ST_LOCKING      1
`define DMR1C_ST_READ_OK      2
`define DMR1C_ST_REFUSED      3
// Timing counts in device clocks
`define DMR1C_MODE_GAP        8
`define DMR1C_DLL_LOCK        1024
`endif

// ---- rtl/dmr1c_ctl.v ----
// Purpose: Host controller programming the first DRAM mode register
// Assumes: DRAM clock is pclk; user inputs are on the pclk domain
// Notes:   APB slave, zero wait states; one command in flight at a time
`timescale 1ns/10ps
`include "dmr1c_defines.vh"

module dmr1c_ctl
#(
  parameter DLL_LOCK_CYCLES = `DMR1C_DLL_LOCK,
  parameter MODE_GAP_CYCLES = `DMR1C_MODE_GAP
)
(
  // Clock, reset, enable
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  // User side
  input  wire        odt_req,
  input  wire        cke_req,
  input  wire        gear_down_quarter,
  output wire        read_allowed,
  output reg         write_time_termination_off,
  // DRAM command/address pins
  output reg         ddr_cs_n,
  output reg         ddr_act_n,
  output reg         ddr_ras_n,
  output reg         ddr_cas_n,
  output reg         ddr_we_n,
  output reg  [1:0]  ddr_bg,
  output reg  [1:0]  ddr_ba,
  output reg         ddr_a17,
  output reg  [13:0] ddr_addr,
  output reg         ddr_cke,
  output reg         ddr_odt
);

  // One-hot sequencer states
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_GAP  = 5'h02;
  localparam [4:0] S_MR0  = 5'h04;
  localparam [4:0] S_LOCK = 5'h08;
  localparam [4:0] S_SPARE = 5'h10;

  // Terminal counts; test builds shrink both to keep runs short
  localparam [31:0] GAP_LAST  = MODE_GAP_CYCLES - 1;
  localparam [31:0] LOCK_LAST = DLL_LOCK_CYCLES - 1;

  // Sequencer state, software images and lock bookkeeping
  reg  [4:0]  state;
  reg  [21:0] mr1_cfg;
  reg  [13:0] mr0_image;
  reg  [21:0] mr1_applied;
  reg         reset_pending;
  reg         lock_pending;
  reg         refused;
  reg  [15:0] gap_cnt;
  reg  [31:0] lock_cnt;

  // Builds a legal first-register payload from a software image
  function [21:0] build_mr1;
    input [21:0] cfg;
    reg   [21:0] w;
    begin
      w = cfg & `DMR1C_MR1_MASK;
      w[`DMR1C_BIT_RSVD_HI] = 1'b0; // RL7
      w[`DMR1C_BIT_RSVD_LO] = 1'b0; // RL7
      w[`DMR1C_SEL_HI:`DMR1C_SEL_LO] = `DMR1C_SEL_MR1; // RL6
      w[`DMR1C_BIT_EQ_HI] = 1'b0; // RL12
      w[`DMR1C_BIT_EQ_MID] = 1'b0; // RL12
      w[`DMR1C_BIT_EQ_LO] = 1'b0; // RL12
      // No nominal termination while the DLL is off
      if (!cfg[`DMR1C_BIT_DLL_EN])
        w[`DMR1C_NT_HI:`DMR1C_NT_LO] = `DMR1C_NT_OFF; // RL19
      build_mr1 = w;
    end
  endfunction

  // Builds the DLL reset payload on the zeroth register
  function [21:0] build_mr0_reset;
    input [13:0] img;
    reg   [21:0] w;
    begin
      w = {8'h00, img};
      w[`DMR1C_SEL_HI:`DMR1C_SEL_LO] = `DMR1C_SEL_MR0; // RL6
      w[`DMR1C_BIT_DLL_RESET] = 1'b1;
      build_mr0_reset = w;
    end
  endfunction

  // Full-word address match; a partial decode would alias registers
  function addr_hit;
    input [11:0] a;
    input [11:0] ofs;
    begin
      addr_hit = (a == ofs);
    end
  endfunction

  // Payloads for both mode sets; pins take fixed slices of them
  wire [21:0] mr1_pay  = build_mr1(mr1_cfg);
  wire [21:0] mr0_pay  = build_mr0_reset(mr0_image);

  // APB decode, zero wait states
  wire        apb_wr   = psel & penable & pwrite & clk_en;
  wire        apb_rd   = psel & penable & ~pwrite;
  wire        hit_cfg  = addr_hit(paddr, `DMR1C_OFS_MR1_CFG);
  wire        hit_mr0  = addr_hit(paddr, `DMR1C_OFS_MR0_IMAGE);
  wire        hit_cmd  = addr_hit(paddr, `DMR1C_OFS_COMMAND);
  wire        hit_st   = addr_hit(paddr, `DMR1C_OFS_STATUS);
  wire        mapped   = hit_cfg | hit_mr0 | hit_cmd | hit_st;
  wire        go_apply = apb_wr & hit_cmd & pwdata[`DMR1C_CMD_APPLY];
  wire        go_reset = apb_wr & hit_cmd & pwdata[`DMR1C_CMD_DLL_RESET];
  wire        idle     = state[0];
  wire        locking  = state[3];
  wire        dll_on   = mr1_applied[`DMR1C_BIT_DLL_EN];
  wire [1:0]  new_al   = mr1_cfg[`DMR1C_AL_HI:`DMR1C_AL_LO];
  wire        al_bad   = gear_down_quarter & (new_al == `DMR1C_AL_MINUS_ONE);
  // Gear-down conflict refuses the apply rather than rewriting it
  wire        take_app = go_apply & idle & ~al_bad; // RL14
  // A DLL reset only makes sense with the DLL running
  wire        take_rst = go_reset & ~go_apply & idle & dll_on;
  wire        refuse   = (go_apply & ~take_app) | (go_reset & ~take_rst & ~take_app);

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Reads and DLL-dependent traffic wait out the lock interval
  assign read_allowed = ~locking & ~lock_pending & ~reset_pending; // RL3

  // APB read data
  always @*
  begin
    prdata = 32'h0000_0000;
    if (apb_rd)
    begin
      if (hit_cfg)
        prdata = {10'h000, mr1_cfg};
      else if (hit_mr0)
        prdata = {18'h0_0000, mr0_image};
      else if (hit_st)
      begin
        // Live status; refused stays until software clears it
        prdata[`DMR1C_ST_BUSY]    = ~idle;
        prdata[`DMR1C_ST_LOCKING] = locking;
        prdata[`DMR1C_ST_READ_OK] = read_allowed;
        prdata[`DMR1C_ST_REFUSED] = refused;
      end
    end
  end

  // Software registers; a new refusal wins over a clear
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mr1_cfg   <= `DMR1C_MR1_RESET;
      mr0_image <= 14'h0000;
      refused   <= 1'b0;
    end
    else if (clk_en)
    begin
      // Writes while the clock enable is low are lost
      if (apb_wr & hit_cfg)
        mr1_cfg <= pwdata[21:0] & `DMR1C_MR1_MASK;
      if (apb_wr & hit_mr0)
        mr0_image <= pwdata[13:0];
      if (refuse)
        refused <= 1'b1;
      else if (apb_wr & hit_st & pwdata[`DMR1C_ST_REFUSED])
        refused <= 1'b0;
    end
  end

  // Command sequencer and DRAM pin drive
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state         <= S_IDLE;
      mr1_applied   <= `DMR1C_MR1_RESET;
      reset_pending <= 1'b0;
      lock_pending  <= 1'b0;
      gap_cnt       <= 16'h0000;
      lock_cnt      <= 32'h0000_0000;
      ddr_cs_n      <= 1'b1;
      ddr_act_n     <= 1'b1;
      ddr_ras_n     <= 1'b1;
      ddr_cas_n     <= 1'b1;
      ddr_we_n      <= 1'b1;
      ddr_bg        <= 2'h0;
      ddr_ba        <= 2'h0;
      ddr_a17       <= 1'b0;
      ddr_addr      <= 14'h0000;
    end
    else if (clk_en)
    begin
      // Command pins idle unless a mode set goes out this cycle
      ddr_cs_n  <= 1'b1;
      ddr_ras_n <= 1'b1;
      ddr_cas_n <= 1'b1;
      ddr_we_n  <= 1'b1;
      ddr_act_n <= 1'b1;
      case (state)
        S_IDLE:
        begin
          if (take_app)
          begin
            ddr_cs_n  <= 1'b0;
            ddr_ras_n <= 1'b0; // RL5
            ddr_cas_n <= 1'b0; // RL5
            ddr_we_n  <= 1'b0; // RL5
            // Payload bits 16 to 14 have no pin and are dropped
            {ddr_bg, ddr_ba, ddr_a17} <= mr1_pay[21:17]; // RL5
            ddr_addr  <= mr1_pay[13:0]; // RL5
            mr1_applied <= mr1_pay;
            // Fresh DLL enable is followed by a DLL reset
            reset_pending <= mr1_cfg[`DMR1C_BIT_DLL_EN] & ~dll_on; // RL2
            gap_cnt   <= 16'h0000;
            state     <= S_GAP;
          end
          else if (take_rst)
          begin
            // Explicit reset skips the first register
            reset_pending <= 1'b1;
            state         <= S_MR0;
          end
        end
        S_GAP:
        begin
          // Spacing between mode sets, then reset or lock wait
          if (gap_cnt == GAP_LAST[15:0])
          begin
            if (reset_pending)
              state <= S_MR0;
            else if (lock_pending)
            begin
              lock_pending <= 1'b0;
              lock_cnt     <= 32'h0000_0000;
              state        <= S_LOCK;
            end
            else
              state <= S_IDLE;
          end
          else
            gap_cnt <= gap_cnt + 16'h0001;
        end
        S_MR0:
        begin
          ddr_cs_n  <= 1'b0;
          ddr_ras_n <= 1'b0; // RL5
          ddr_cas_n <= 1'b0; // RL5
          ddr_we_n  <= 1'b0; // RL5
          // Zeroth register with the DLL reset bit raised
          {ddr_bg, ddr_ba, ddr_a17} <= mr0_pay[21:17];
          ddr_addr  <= mr0_pay[13:0];
          reset_pending <= 1'b0;
          lock_pending  <= 1'b1; // RL3
          gap_cnt   <= 16'h0000;
          state     <= S_GAP;
        end
        S_LOCK:
        begin
          // Lock wait counted in device clocks
          if (lock_cnt == LOCK_LAST)
            state <= S_IDLE; // RL3
          else
            lock_cnt <= lock_cnt + 32'h0000_0001;
        end
        // Stray codes fall back to idle
        default:
          state <= S_IDLE;
      endcase
    end
  end

  // Clock enable, termination pin and write-time termination request
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ddr_cke <= 1'b0;
      ddr_odt <= 1'b0;
      write_time_termination_off <= 1'b0;
    end
    else if (clk_en)
    begin
      // Lock wait forces clock enable high whatever the user asks
      ddr_cke <= cke_req | locking | lock_pending; // RL4
      // Termination pin low with DLL off or not yet locked
      ddr_odt <= odt_req & dll_on & read_allowed & ~locking; // RL19
      write_time_termination_off <= ~dll_on; // RL20
    end
  end

endmodule // dmr1c_ctl

// ---- testbench/dmr1c_asserts.sv ----
// Purpose: Port checker for the mode register controller
// Assumes: Sim counts are small
// Notes:   Bound to every controller instance
`timescale 1ns/10ps
module dmr1c_asserts (
  // Clock and bus
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic [11:0] paddr,
  input logic        pslverr,
  input logic        gear_down_quarter,
  // Pins
  input logic        read_allowed,
  input logic        ddr_cs_n,
  input logic        ddr_act_n,
  input logic        ddr_ras_n,
  input logic        ddr_cas_n,
  input logic        ddr_we_n,
  input logic [1:0]  ddr_bg,
  input logic [1:0]  ddr_ba,
  input logic        ddr_a17,
  input logic [13:0] ddr_addr,
  input logic        ddr_cke
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Mode set strobes and selects
  sequence s_mrs; !ddr_cs_n; endsequence
  sequence s_rst; !ddr_cs_n && ddr_ba == 2'b00 && ddr_addr[8]; endsequence
  property p_cmd; s_mrs |-> !ddr_ras_n && !ddr_cas_n && !ddr_we_n && ddr_act_n; endproperty
  a_cmd: assert property (p_cmd) else $error("mode set strobes wrong");
  property p_one; s_mrs |=> ddr_cs_n; endproperty
  a_one: assert property (p_one) else $error("strobe longer than a cycle");
  property p_sel; s_mrs |-> !ddr_bg[0] && ddr_ba[1] == 1'b0; endproperty
  a_sel: assert property (p_sel) else $error("bad register select");
  property p_rsv; s_mrs |-> !ddr_bg[1] && !ddr_a17; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_eq; s_mrs and ddr_ba == 2'b01 |-> ddr_addr[13] == 1'b0 && ddr_addr[6:5] == 2'b00;
  endproperty
  a_eq: assert property (p_eq) else $error("equaliser not zero");
  property p_nt; s_mrs and ddr_ba == 2'b01 && !ddr_addr[0] |-> ddr_addr[10:8] == 3'b000;
  endproperty
  a_nt: assert property (p_nt) else $error("termination on with DLL off");
  property p_gear; s_mrs and ddr_ba == 2'b01 && gear_down_quarter |-> ddr_addr[4:3] != 2'b01;
  endproperty
  a_gear: assert property (p_gear) else $error("latency code with gear-down");
  property p_lock; s_rst |-> !read_allowed [*6]; endproperty
  a_lock: assert property (p_lock) else $error("read allowed during lock");
  property p_cke; s_rst |=> ddr_cke [*6]; endproperty
  a_cke: assert property (p_cke) else $error("clock enable low in lock");
  property p_err; psel && penable && paddr > 12'h00C |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("unmapped access not flagged");
endmodule // dmr1c_asserts
bind dmr1c_ctl dmr1c_asserts u_chk (.pclk, .presetn, .psel, .penable, .paddr, .pslverr,
  .gear_down_quarter, .read_allowed, .ddr_cs_n, .ddr_act_n, .ddr_ras_n, .ddr_cas_n,
  .ddr_we_n, .ddr_bg, .ddr_ba, .ddr_a17, .ddr_addr, .ddr_cke);

// ---- testbench/dmr1c_dram.sv ----
// Purpose: Behavioural memory side taking mode sets
// Assumes: Same clock as the controller
// Notes:   Flags host misbehaviour on viol
`timescale 1ns/10ps
module dmr1c_dram #(parameter LOCK = 4, parameter CAS = 11) (
  // Pins
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        cs_n, ras_n, cas_n, we_n, a17, cke,
  input  wire logic [1:0]  bg, ba,
  input  wire logic [13:0] addr,
  // Observed state
  output logic      [21:0] last,
  output logic      [21:0] mr1,
  output logic      [7:0]  resets,
  output logic             viol
);
  logic [7:0] lk;
  wire [21:0] pay = {bg, ba, a17, 3'b000, addr};
  // Decoded fields of the first register
  wire dll_on = mr1[0] & cke;
  wire out_off = mr1[12];
  wire extra_ts = mr1[11];
  wire [2:0] nom_term = out_off ? 3'b000 : mr1[10:8];
  wire wlevel = mr1[7];
  wire [1:0] drv = mr1[2:1];
  wire [7:0] rd_lat = CAS + (mr1[4:3] == 2'b01 ? CAS - 1 : mr1[4:3] == 2'b10 ? CAS - 2 : 0);
  // Command decode, lock wait and misuse flags
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      mr1 <= 22'h00_0000; last <= 22'h00_0000; resets <= 8'h00; lk <= 8'h00; viol <= 1'b0;
    end
    else
    begin
      if (lk != 8'h00) lk <= lk - 8'h01;
      if (lk != 8'h00 && !cke) viol <= 1'b1;
      if (!cs_n && !ras_n && !cas_n && !we_n)
      begin
        last <= pay;
        if (pay[20:18] == 3'b001) mr1 <= pay;
        if (pay[21] | pay[17]) viol <= 1'b1;
        if (pay[20:18] == 3'b000 && pay[8])
        begin
          resets <= resets + 8'h01;  // reset bit not kept
          lk <= LOCK[7:0];
        end
      end
    end
endmodule // dmr1c_dram

// ---- testbench/test_dmr1c_ctl.sv ----
// Purpose: Self-checking bench for the mode register controller
// Assumes: Short lock and gap counts
// Notes:   APB master plus memory model
`timescale 1ns/10ps
module test_dmr1c_ctl;
  logic pclk, presetn, psel, penable, pwrite, gear, pready, pslverr, rda, wtt, e;
  logic cs_n, act_n, ras_n, cas_n, we_n, a17, cke, odt, viol, clk_en, odt_req, cke_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [1:0] bg, ba;
  logic [13:0] addr;
  logic [21:0] last, mr1;
  logic [7:0] resets, n0;
  int err_total, total_checks, cyc;
  dmr1c_ctl #(.DLL_LOCK_CYCLES(4), .MODE_GAP_CYCLES(2)) i_dmr1c_ctl (.pclk, .presetn,
    .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
    .odt_req, .cke_req, .gear_down_quarter(gear), .read_allowed(rda),
    .write_time_termination_off(wtt), .ddr_cs_n(cs_n), .ddr_act_n(act_n), .ddr_ras_n(ras_n),
    .ddr_cas_n(cas_n), .ddr_we_n(we_n), .ddr_bg(bg), .ddr_ba(ba), .ddr_a17(a17),
    .ddr_addr(addr), .ddr_cke(cke), .ddr_odt(odt));
  dmr1c_dram #(.LOCK(4)) i_dmr1c_dram (.pclk, .presetn, .cs_n, .ras_n, .cas_n, .we_n, .a17,
    .cke, .bg, .ba, .addr, .last, .mr1, .resets, .viol);
  task end_sim;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask
  // One APB transfer, waits for pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Program, apply and wait for idle
  task run(input logic [31:0] cfg, input logic [31:0] cmd);
    apb(1, 12'h000, cfg);
    apb(1, 12'h008, cmd);
    do apb(0, 12'h00C, 0); while (r[0] !== 1'b0);
  endtask
  task t_regs;
    apb(0, 12'h000, 0); chk("cfg reset", 32'h0000_0001, r);
    apb(0, 12'h004, 0); chk("image reset", 32'h0000_0000, r);
    apb(1, 12'h000, 32'hFFFF_FFFF); apb(0, 12'h000, 0); chk("cfg mask", 32'h0000_1F9F, r);
    apb(0, 12'h008, 0); chk("cmd reads", 32'h0000_0000, r);
    apb(1, 12'h010, 32'h1); chk("unmapped err", 1, e);
  endtask
  task t_all_ones;
    run(32'hFFFF_FFFF, 1); chk("payload", 32'h0004_1F9F, last);
  endtask
  task t_codes;
    for (int i = 0; i < 8; i++)
    begin
      run(32'h1 | (i << 8) | ((i % 3) << 3) | ((i % 2) << 1), 1);
      chk("fields", 32'h0004_0001 | (i << 8) | ((i % 3) << 3) | ((i % 2) << 1), mr1);
    end
  endtask
  task t_dll_off;
    odt_req <= 1'b1;
    run(32'h0000_1F00, 1); chk("nt off", 32'h0004_1800, last);
    chk("wtt off", 1, wtt);
    chk("odt off", 0, odt);
  endtask
  task t_dll_on;
    n0 = resets;
    run(32'h0000_0081, 1); chk("dll reset", n0 + 1, resets);
    chk("reset payload", 32'h0000_0100, last);
    chk("read ok", 1, rda);
    chk("wlevel", 32'h0004_0081, mr1);
    apb(0, 12'h004, 0); chk("image clean", 0, r[8]);
    chk("odt on", 1, odt);
    run(32'h0000_0001, 2); chk("reset cmd", n0 + 2, resets);
  endtask
  task t_gear;
    gear <= 1'b1;
    run(32'h0000_0009, 1); chk("refused", 1, r[3]);
    chk("not sent", 32'h0004_0081, mr1);
    run(32'h0000_0011, 1); chk("al minus two", 32'h0004_0011, mr1);
    apb(1, 12'h00C, 32'h8); gear <= 1'b0;
    apb(0, 12'h00C, 0); chk("refused clear", 0, r[3]);
  endtask
  task t_hold;
    clk_en <= 1'b0; cke_req <= 1'b1;
    apb(1, 12'h004, 32'h0000_002A); clk_en <= 1'b1;
    apb(0, 12'h004, 0); chk("frozen write", 0, r);
    chk("cke request", 1, cke);
    apb(1, 12'h004, 32'h0000_002A); apb(0, 12'h004, 0); chk("image write", 32'h0000_002A, r);
    cke_req <= 1'b0;
  endtask
  initial
  begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end
  // Hang guard
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      end_sim;
    end
  end
  initial
  begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; gear = 0;
    clk_en = 1; odt_req = 0; cke_req = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_all_ones;
    t_codes;
    t_dll_off;
    t_dll_on;
    t_gear;
    t_hold;
    chk("host misuse", 0, viol);
    end_sim;
  end
endmodule // test_dmr1c_ctl
